// ---- clk_pwr_pkg.sv ----
// constants and bus carriers for the clock and power control block
// assumes a 32-bit axi4-lite master on the same clock as the block
package clk_pwr_pkg;
    // register byte offsets
    localparam logic [7:0] pll_control_off          = 8'h00;
    localparam logic [7:0] subclock_osc_control_off = 8'h04;
    localparam logic [7:0] main_osc_wait_control_off = 8'h08;
    localparam logic [7:0] clock_output_control_off = 8'h0c;
    localparam logic [7:0] main_osc_drive_control_off = 8'h10;
    localparam logic [7:0] clock_div_control_off    = 8'h14;
    localparam logic [7:0] module_stop_control_off  = 8'h18;
    localparam logic [7:0] power_mode_control_off   = 8'h1c;
    localparam logic [7:0] low_power_control_off    = 8'h20;
    localparam logic [7:0] status_off               = 8'h24;
    // field positions
    localparam int pll_mult_lsb     = 8;
    localparam int cko_src_lsb      = 8;
    localparam int cko_div_lsb      = 12;
    localparam int cko_stop_bit     = 15;
    localparam int drive_bit        = 5;
    // pll multiplier legal code range, x4 .. x12 in half steps
    localparam logic [5:0] pll_mult_min = 6'h07;
    localparam logic [5:0] pll_mult_max = 6'h17;
    // clock output sources
    localparam logic [3:0] cko_low_speed_onchip_osc  = 4'h0;
    localparam logic [3:0] cko_high_speed_onchip_osc  = 4'h1;
    localparam logic [3:0] cko_main  = 4'h2;
    localparam logic [3:0] cko_sub   = 4'h3;
    localparam logic [3:0] cko_pll   = 4'h4;
    localparam logic [3:0] cko_touch = 4'h8;
    // operating power modes
    localparam logic [2:0] opm_high  = 3'h0;
    localparam logic [2:0] opm_mid   = 3'h2;
    localparam logic [2:0] opm_mid2  = 3'h4;
    localparam logic [2:0] opm_low   = 3'h6;
    // main oscillator wait: 2^(code+2) low-speed cycles, code 15 longest
    localparam logic [4:0] wait_code_max  = 5'h0f;
    localparam int         wait_cyc_max   = 131072;
    localparam int         wait_base_log2 = 2;
    // reset values
    localparam logic [15:0] pll_control_rst   = 16'h0f00;
    localparam logic [7:0]  subclock_ctl_rst  = 8'h01;
    localparam logic [7:0]  wait_ctl_rst      = 8'h0f;
    localparam logic [15:0] cko_ctl_rst       = 16'h8000;
    localparam logic [7:0]  drive_ctl_rst     = 8'h00;
    localparam logic [11:0] div_ctl_rst       = 12'h000;
    localparam logic [31:0] mstop_rst         = 32'hffff_ffff;
    // axi responses
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // low-power states
    typedef enum logic [1:0] {st_run, st_sleep, st_deep} lp_state_e;
    // bus carriers
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;
endpackage

// ---- clk_pwr_ctrl.sv ----
// clock generation and low-power control with an axi4-lite register slave
// assumes source ticks and cpu events come from logic on aclk;
// the power-on reset pin is asynchronous and is synchronised here
//
// Summary of operation
// R1: pll multiplier codes 07..17 only, others refused
// R2: subclock stop bit reset only by power-on
// R3: oscillator wait counts low-speed ticks, max 131072
// R4: clock output source select, listed codes only
// R5: clock output divider, divide 1 to 128
// R6: software picks drive bit by resonator frequency
// R7: register plus instruction enters, interrupt exits
// R8: sleep halts cpu only, rest register controlled
// R9: deep sleep halts cpu, ram, transfer controller
// R10: four operating power modes, legal codes only
// R11: each peripheral has its own stop bit
// R12: independent dividers for four internal clocks
// R13: operable units follow own register in low power
// R14: stopped units hold state, operations suspended
`timescale 1ns/1ps
module clk_pwr_ctrl #(
    parameter int wait_max = clk_pwr_pkg::wait_cyc_max // longest wait
) (
    // clock and resets
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   por_n,
    // register bus
    input  wire clk_pwr_pkg::axil_req_s axi_req,
    output clk_pwr_pkg::axil_rsp_s      axi_rsp,
    // clock source ticks: low_speed_onchip_osc, high_speed_onchip_osc, main, sub, pll, touch
    input  wire logic [5:0]             src_tick,
    // cpu side events
    input  wire logic                   sleep_instr,
    input  wire logic                   irq_pending,
    // clock outputs: four one-cycle enables and the toggling output pin
    output logic                        system_clock_en,
    output logic                        peripheral_bus_clock_en,
    output logic                        analog_conv_clock_en,
    output logic                        flash_if_clock_en,
    output logic                        clock_output_pin,
    // oscillator and pll controls
    output logic [5:0]                  pll_mult_sel,
    output logic                        subclock_stop,
    output logic                        main_osc_drive_sel,
    output logic                        main_osc_stable,
    // power controls
    output logic [2:0]                  opm_sel,
    output logic [31:0]                 module_stop,
    output logic                        cpu_halt,
    output logic                        ram_halt,
    output logic                        transfer_controller_halt
);
    // refuse a wait cap below the shortest coded wait (4) or above wait_cyc_max
    if (wait_max < 4 || wait_max > clk_pwr_pkg::wait_cyc_max) begin : g_bad
        $error("wait_max out of range");
    end

    // registers
    logic [15:0] pll_r, cko_r;
    logic [7:0]  sub_r, wait_r, drive_r;
    logic [11:0] div_r;            // 3 bits per internal clock
    logic [31:0] mstop_r;
    logic [2:0]  opm_r;
    logic        deep_sel_r;       // 0 sleep, 1 deep sleep on instruction
    clk_pwr_pkg::lp_state_e lp_r;
    // power-on reset synchroniser
    logic por_m_r, por_s_r;
    // bus state
    logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0]  wstrb_r;
    logic [1:0]  bresp_r, rresp_r;

    // merge write data by byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) m[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return m;
    endfunction

    // write decode: fires when address and data are both held
    wire        do_wr = aw_held_r && w_held_r && !bvalid_r;
    wire [7:0]  wa    = awaddr_r;
    wire        wr_pll  = do_wr && wa == clk_pwr_pkg::pll_control_off;
    wire        wr_sub  = do_wr && wa == clk_pwr_pkg::subclock_osc_control_off;
    wire        wr_wait = do_wr &&
                          wa == clk_pwr_pkg::main_osc_wait_control_off;
    wire        wr_cko  = do_wr && wa == clk_pwr_pkg::clock_output_control_off;
    wire        wr_drv  = do_wr &&
                          wa == clk_pwr_pkg::main_osc_drive_control_off;
    wire        wr_div  = do_wr && wa == clk_pwr_pkg::clock_div_control_off;
    wire        wr_mst  = do_wr && wa == clk_pwr_pkg::module_stop_control_off;
    wire        wr_opm  = do_wr && wa == clk_pwr_pkg::power_mode_control_off;
    wire        wr_lp   = do_wr && wa == clk_pwr_pkg::low_power_control_off;
    wire        wr_hit  = wr_pll | wr_sub | wr_wait | wr_cko | wr_drv |
                          wr_div | wr_mst | wr_opm | wr_lp;

    // proposed values after byte-lane merge
    wire [31:0] pll_nxt  = merge({16'h0, pll_r}, wdata_r, wstrb_r);
    wire [31:0] wait_nxt = merge({24'h0, wait_r}, wdata_r, wstrb_r);
    wire [31:0] cko_nxt  = merge({16'h0, cko_r}, wdata_r, wstrb_r);
    wire [31:0] opm_nxt  = merge({29'h0, opm_r}, wdata_r, wstrb_r);
    wire [31:0] drv_nxt  = merge({24'h0, drive_r}, wdata_r, wstrb_r);
    wire [31:0] div_nxt  = merge({20'h0, div_r}, wdata_r, wstrb_r);
    wire [31:0] sub_nxt  = merge({24'h0, sub_r}, wdata_r, wstrb_r);
    wire [5:0]  mult_f   = pll_nxt[clk_pwr_pkg::pll_mult_lsb +: 6];
    wire [3:0]  src_f    = cko_nxt[clk_pwr_pkg::cko_src_lsb +: 4];
    // prohibited codes are refused and the old field stays
    wire mult_ok = mult_f >= clk_pwr_pkg::pll_mult_min &&
                   mult_f <= clk_pwr_pkg::pll_mult_max;          // [R1]
    wire wait_ok = wait_nxt[4:0] <= clk_pwr_pkg::wait_code_max;  // [R3]
    wire src_ok  = src_f <= clk_pwr_pkg::cko_pll ||
                   src_f == clk_pwr_pkg::cko_touch;              // [R4]
    wire opm_ok  = !opm_nxt[0];                                  // [R10]

    // read decode
    wire [7:0]  ra = axi_req.araddr;
    logic [31:0] rd_val;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (ra)
            clk_pwr_pkg::pll_control_off:           rd_val = {16'h0, pll_r};
            clk_pwr_pkg::subclock_osc_control_off:  rd_val = {24'h0, sub_r};
            clk_pwr_pkg::main_osc_wait_control_off: rd_val = {24'h0, wait_r};
            clk_pwr_pkg::clock_output_control_off:  rd_val = {16'h0, cko_r};
            clk_pwr_pkg::main_osc_drive_control_off:
                rd_val = {24'h0, drive_r};
            clk_pwr_pkg::clock_div_control_off:     rd_val = {20'h0, div_r};
            clk_pwr_pkg::module_stop_control_off:   rd_val = mstop_r;
            clk_pwr_pkg::power_mode_control_off:    rd_val = {29'h0, opm_r};
            clk_pwr_pkg::low_power_control_off:
                rd_val = {31'h0, deep_sel_r};
            // status shows the block's own state
            clk_pwr_pkg::status_off:
                rd_val = {26'h0, opm_r, lp_r, main_osc_stable};
            default: begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // bus handshake outputs
    assign axi_rsp.awready = !aw_held_r && !bvalid_r;
    assign axi_rsp.wready  = !w_held_r && !bvalid_r;
    assign axi_rsp.bvalid  = bvalid_r;
    assign axi_rsp.bresp   = bresp_r;
    assign axi_rsp.arready = !rvalid_r;
    assign axi_rsp.rvalid  = rvalid_r;
    assign axi_rsp.rdata   = rdata_r;
    assign axi_rsp.rresp   = rresp_r;

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= clk_pwr_pkg::resp_okay;
            awaddr_r  <= 8'h0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= axi_req.awaddr;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= axi_req.wdata;
                wstrb_r  <= axi_req.wstrb;
            end
            if (do_wr) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? clk_pwr_pkg::resp_okay
                                    : clk_pwr_pkg::resp_slverr;
            end else if (bvalid_r && axi_req.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= clk_pwr_pkg::resp_okay;
        end else if (axi_req.arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_hit ? clk_pwr_pkg::resp_okay
                               : clk_pwr_pkg::resp_slverr;
        end else if (rvalid_r && axi_req.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // configuration registers set to their reset values by aresetn only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_r      <= clk_pwr_pkg::pll_control_rst;
            wait_r     <= clk_pwr_pkg::wait_ctl_rst;
            cko_r      <= clk_pwr_pkg::cko_ctl_rst;
            drive_r    <= clk_pwr_pkg::drive_ctl_rst;
            div_r      <= clk_pwr_pkg::div_ctl_rst;
            mstop_r    <= clk_pwr_pkg::mstop_rst;
            opm_r      <= clk_pwr_pkg::opm_high;
            deep_sel_r <= 1'b0;
        end else begin
            if (wr_pll && mult_ok) pll_r <= {2'h0, mult_f, 8'h0};  // [R1]
            if (wr_wait && wait_ok) wait_r <= {3'h0, wait_nxt[4:0]}; // [R3]
            // source and divider written together; bad source refused
            if (wr_cko && src_ok) cko_r <= {cko_nxt[15:12], src_f, 8'h0};
            // drive choice is software's job; bit 5 stored as written [R6]
            if (wr_drv) drive_r <= drv_nxt[7:0] & 8'h20;
            if (wr_div) div_r <= div_nxt[11:0];                 // [R12]
            if (wr_mst) mstop_r <= merge(mstop_r, wdata_r, wstrb_r); // [R11]
            if (wr_opm && opm_ok) opm_r <= opm_nxt[2:0];        // [R10]
            // a write without the low byte lane leaves the choice alone
            if (wr_lp && wstrb_r[0]) deep_sel_r <= wdata_r[0];  // [R7]
        end
    end

    // power-on reset pin passes two flops before use
    always_ff @(posedge aclk) begin
        por_m_r <= por_n;
        por_s_r <= por_m_r;
    end

    // subclock stop survives every reset except power-on
    always_ff @(posedge aclk) begin
        if (!por_s_r) begin
            sub_r <= clk_pwr_pkg::subclock_ctl_rst;               // [R2]
        end else if (wr_sub) begin
            sub_r <= sub_nxt[7:0] & 8'h01;
        end
    end

    // main oscillator wait counter, restarted by reset or a new setting
    logic [17:0] wait_cnt_r;
    wire  [4:0]  wcode = wait_r[4:0];
    wire  [17:0] wait_tgt = 18'(1) <<
                            (wcode + 5'(clk_pwr_pkg::wait_base_log2));
    wire  [17:0] wait_lim = (wait_tgt > 18'(wait_max)) ? 18'(wait_max)
                                                       : wait_tgt;
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_wait) begin
            wait_cnt_r      <= 18'h0;
            main_osc_stable <= 1'b0;
        end else if (src_tick[0] && !main_osc_stable) begin
            // counted in low-speed oscillator ticks only [R3]
            wait_cnt_r      <= wait_cnt_r + 18'h1;
            main_osc_stable <= (wait_cnt_r + 18'h1) == wait_lim;
        end
    end

    // clock output: selected tick divided by 2^div, toggling the pin
    logic [6:0] cko_cnt_r;
    wire  [2:0] cko_div = cko_r[clk_pwr_pkg::cko_div_lsb +: 3];
    wire  [3:0] cko_src = cko_r[clk_pwr_pkg::cko_src_lsb +: 4];
    wire  [6:0] cko_mask = 7'((8'h1 << cko_div) - 8'h1);           // [R5]
    wire        cko_tick = (cko_src == clk_pwr_pkg::cko_touch) ?
                           src_tick[5] : src_tick[cko_src[2:0]];  // [R4]
    always_ff @(posedge aclk) begin
        if (!aresetn || cko_r[clk_pwr_pkg::cko_stop_bit]) begin
            cko_cnt_r        <= 7'h0;
            clock_output_pin <= 1'b0;
        end else if (cko_tick) begin
            cko_cnt_r <= cko_cnt_r + 7'h1;
            if ((cko_cnt_r & cko_mask) == cko_mask)
                clock_output_pin <= !clock_output_pin;            // [R5]
        end
    end

    // internal clock enables from one free counter, one per field
    logic [6:0] div_cnt_r;
    logic [3:0] clk_en;
    always_ff @(posedge aclk) begin
        if (!aresetn) div_cnt_r <= 7'h0;
        else          div_cnt_r <= div_cnt_r + 7'h1;
    end
    for (genvar g = 0; g < 4; g++) begin : g_div
        wire [2:0] sel  = div_r[g*3 +: 3];
        wire [6:0] mask = 7'((8'h1 << sel) - 8'h1);
        assign clk_en[g] = (div_cnt_r & mask) == mask;              // [R12]
    end
    // the cpu shares the system clock but is gated by cpu_halt
    assign system_clock_en         = clk_en[0];
    assign peripheral_bus_clock_en = clk_en[1];
    assign analog_conv_clock_en    = clk_en[2];
    assign flash_if_clock_en       = clk_en[3];

    // low-power sequencer: entry on instruction, exit on interrupt
    clk_pwr_pkg::lp_state_e lp_nxt;
    always_comb begin
        lp_nxt = lp_r;
        unique case (lp_r)
            clk_pwr_pkg::st_run:
                if (sleep_instr && !irq_pending)                 // [R7]
                    lp_nxt = deep_sel_r ? clk_pwr_pkg::st_deep
                                        : clk_pwr_pkg::st_sleep;
            clk_pwr_pkg::st_sleep,
            clk_pwr_pkg::st_deep:
                if (irq_pending) lp_nxt = clk_pwr_pkg::st_run;   // [R7]
            default: lp_nxt = clk_pwr_pkg::st_run;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) lp_r <= clk_pwr_pkg::st_run;
        else          lp_r <= lp_nxt;
    end

    // halts hold state in place; units resume where they stopped [R14]
    assign cpu_halt = lp_r != clk_pwr_pkg::st_run;                // [R8]
    assign ram_halt = lp_r == clk_pwr_pkg::st_deep;               // [R9]
    assign transfer_controller_halt = lp_r == clk_pwr_pkg::st_deep; // [R9]
    // peripherals, oscillators and pll keep obeying registers [R13]
    assign module_stop        = mstop_r;
    assign pll_mult_sel       = pll_r[clk_pwr_pkg::pll_mult_lsb +: 6];
    assign subclock_stop      = sub_r[0];
    assign main_osc_drive_sel = drive_r[clk_pwr_pkg::drive_bit];
    assign opm_sel            = opm_r;
endmodule

// ---- clk_pwr_ctrl_checker.sv ----
// port assertions for the clock and power control block
// assumes it is bound onto clk_pwr_ctrl, all on one aclk domain
`timescale 1ns/1ps
module clk_pwr_ctrl_checker (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // register bus
    input wire clk_pwr_pkg::axil_req_s axi_req,
    input wire clk_pwr_pkg::axil_rsp_s axi_rsp,
    // cpu events
    input wire logic                   sleep_instr,
    input wire logic                   irq_pending,
    // watched controls
    input wire logic [5:0]             pll_mult_sel,
    input wire logic [2:0]             opm_sel,
    input wire logic                   cpu_halt,
    input wire logic                   ram_halt,
    input wire logic                   transfer_controller_halt
);
    // one domain, so clock and reset are declared once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus answers come and stand until taken
    wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready &&
        axi_req.wvalid && axi_rsp.wready |-> ##[1:3] axi_rsp.bvalid)
        else $error("write answer missing");
    rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid) else $error("read answer missing");
    rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
    wr_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid) else $error("write answer dropped");
    // the multiplier and the power mode never leave their legal spans
    pll_legal_a: assert property (pll_mult_sel >= clk_pwr_pkg::pll_mult_min
        && pll_mult_sel <= clk_pwr_pkg::pll_mult_max)
        else $error("pll code illegal");
    opm_legal_a: assert property (!opm_sel[0])
        else $error("power mode illegal");
    // low-power entry, exit and retention
    sleep_enter_a: assert property (!cpu_halt && sleep_instr &&
        !irq_pending |=> cpu_halt) else $error("sleep not entered");
    wake_up_a: assert property (cpu_halt && irq_pending |=> !cpu_halt)
        else $error("interrupt did not wake");
    halt_kept_a: assert property (cpu_halt && !irq_pending |=>
        cpu_halt && $stable(ram_halt)) else $error("halt not kept");
    deep_halt_a: assert property (ram_halt |-> cpu_halt &&
        transfer_controller_halt) else $error("deep halt incomplete");
endmodule

bind clk_pwr_ctrl clk_pwr_ctrl_checker i_chk (.aclk, .aresetn, .axi_req,
    .axi_rsp, .sleep_instr, .irq_pending, .pll_mult_sel, .opm_sel,
    .cpu_halt, .ram_halt, .transfer_controller_halt);

// ---- clk_pwr_ctrl_bench.sv ----
// self-checking bench for the clock and power control block
// assumes the bench alone drives every input on one 25 MHz clock
`timescale 1ns/1ps
module clk_pwr_ctrl_bench;
    localparam int wmax = 16; // short wait cap keeps the run brief
    logic aclk, aresetn, por_n, sleep_instr, irq_pending;
    clk_pwr_pkg::axil_req_s req;
    clk_pwr_pkg::axil_rsp_s rsp;
    logic [5:0]  src_tick, pll;
    wire  [3:0]  en;    // system, peripheral, analog, flash enables
    logic        pin, sub, drv, stable, ch, rh, th;
    logic [2:0]  opm;
    logic [31:0] mstop, rdat;
    logic [1:0]  bresp_q, rresp_q;
    int          failures, n_tests, tgl, n;
    int          ec [4];
    logic [31:0] pw [6] = '{32'h0700, 32'h1700, 32'h0600, 32'h1800,
                            32'h3f00, 32'h0c00};
    logic [31:0] pe [6] = '{32'h0700, 32'h1700, 32'h1700, 32'h1700,
                            32'h1700, 32'h0c00};
    logic [7:0]  da [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                            8'h18, 8'h1c, 8'h20};
    logic [31:0] de [9] = '{32'h0f00, 32'h01, 32'h0f, 32'h8000, 32'h0,
                            32'h0, 32'hffff_ffff, 32'h0, 32'h0};
    logic [3:0]  srcs [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic [2:0]  modes [5] = '{3'h2, 3'h4, 3'h6, 3'h0, 3'h3};

    clk_pwr_ctrl #(.wait_max(wmax)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .por_n(por_n), .axi_req(req), .axi_rsp(rsp), .src_tick(src_tick),
        .sleep_instr(sleep_instr), .irq_pending(irq_pending),
        .system_clock_en(en[0]), .peripheral_bus_clock_en(en[1]),
        .analog_conv_clock_en(en[2]), .flash_if_clock_en(en[3]),
        .clock_output_pin(pin), .pll_mult_sel(pll), .subclock_stop(sub),
        .main_osc_drive_sel(drv), .main_osc_stable(stable), .opm_sel(opm),
        .module_stop(mstop), .cpu_halt(ch), .ram_halt(rh),
        .transfer_controller_halt(th));

    // free-running 40 ns clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // count and report one comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus write; address and data offered together
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d,
                 wstrb:4'hf, bready:1'b1, default:'0};
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        bresp_q = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    // one bus read; data taken at the edge rvalid is seen
    task rd(input logic [7:0] a);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rdat = rsp.rdata;
        rresp_q = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    // k source pulses two cycles apart, counting output pin toggles
    task ticks(input logic [5:0] m, input int k);
        logic last;
        last = pin;
        tgl = 0;
        repeat (k + 2) begin
            @(posedge aclk);
            if (pin !== last) tgl++;
            last = pin;
            src_tick <= (k > 0) ? m : 6'h00;
            k = k - 1;
            @(posedge aclk);
            src_tick <= 6'h00;
        end
    endtask
    // one-cycle event pulse, then let the state register settle
    task cpu_event(input logic slp, input logic irq);
        @(posedge aclk);
        sleep_instr <= slp;
        irq_pending <= irq;
        @(posedge aclk);
        sleep_instr <= 1'b0;
        irq_pending <= 1'b0;
        @(posedge aclk);
    endtask
    // single place the run ends
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard, well beyond the roughly 5000 cycles the tests need
    initial begin
        repeat (30000) @(posedge aclk);
        failures++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        {aresetn, por_n, sleep_instr, irq_pending} = 4'h0;
        {req, src_tick} = '0;
        failures = 0;
        n_tests = 0;
        repeat (4) @(posedge aclk);
        por_n <= 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(da[i]);
            chk(rdat, de[i]);
        end
        ticks(6'h3f, 2);
        chk(tgl, 0);
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, pw[i]);
            rd(8'h00);
            chk(rdat, pe[i]);
            chk(pll, pe[i][13:8]);
        end
        // subclock stop survives a plain reset, only power-on sets it
        wr(8'h04, 32'h0);
        chk(sub, 1'b0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h04);
        chk(rdat, 32'h0);
        por_n <= 1'b0;
        repeat (4) @(posedge aclk);
        por_n <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(8'h04);
        chk(rdat, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h08, c);
            repeat (2) @(posedge aclk);
            for (n = 0; stable !== 1'b1 && n < 40; n++) ticks(6'h01, 1);
            chk(n, (c < 3) ? (4 << c) : wmax);
        end
        wr(8'h08, 32'h10);
        rd(8'h08);
        chk(rdat, 32'h3);
        for (int s = 0; s < 6; s++) begin
            wr(8'h0c, {20'h0, srcs[s], 8'h00});
            ticks(~(6'h01 << s), 4);
            chk(tgl, 0);
            ticks(6'h01 << s, 4);
            chk(tgl, 4);
        end
        for (int d = 0; d < 8; d++) begin
            wr(8'h0c, d << 12);
            ticks(6'h01, 256);
            chk(tgl, 256 >> d);
        end
        wr(8'h0c, 32'h3500);
        chk(bresp_q, clk_pwr_pkg::resp_okay);
        rd(8'h0c);
        chk(rdat, 32'h7000);
        wr(8'h14, {20'h0, 3'd4, 3'd3, 3'd2, 3'd1});
        ec = '{0, 0, 0, 0};
        repeat (128) begin
            @(posedge aclk);
            for (int i = 0; i < 4; i++) ec[i] += (en[i] === 1'b1);
        end
        for (int i = 0; i < 4; i++) chk(ec[i], 128 >> (i + 1));
        wr(8'h18, 32'ha5a5_5a5a);
        chk(mstop, 32'ha5a5_5a5a);
        wr(8'h10, 32'h20);
        chk(drv, 1'b1);
        for (int i = 0; i < 5; i++) begin
            wr(8'h1c, modes[i]);
            chk(opm, (i < 4) ? modes[i] : 3'h0);
        end
        // sleep, a write while asleep, wake; then deep sleep
        wr(8'h20, 32'h0);
        cpu_event(1'b1, 1'b0);
        chk({ch, rh, th}, 3'b100);
        wr(8'h18, 32'h0);
        chk(mstop, 32'h0);
        cpu_event(1'b0, 1'b1);
        chk({ch, rh, th}, 3'b000);
        cpu_event(1'b1, 1'b1);
        chk(ch, 1'b0);
        wr(8'h20, 32'h1);
        cpu_event(1'b1, 1'b0);
        chk({ch, rh, th}, 3'b111);
        rd(8'h24);
        chk(rdat[2:1], 2'h2);
        cpu_event(1'b0, 1'b1);
        chk({ch, rh, th}, 3'b000);
        rd(8'h28);
        chk(rresp_q, clk_pwr_pkg::resp_slverr);
        wr(8'h3c, 32'h1);
        chk(bresp_q, clk_pwr_pkg::resp_slverr);
        tally_and_finish;
    end
endmodule
